// [logic/slc_pkg.sv]
// Shared constants, types and helpers for the servo loop compensation filters.
// Assumes a single 10 MHz core clock and a control loop that runs on the sample tick.
package slc_pkg;

  // Clock and control sample timing
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned SAMPLE_PERIOD_NS = 25000;
  localparam int unsigned SAMPLE_DIV       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_US        = SAMPLE_PERIOD_NS / 1000;
  localparam int unsigned SAMPLE_RATE_HZ   = 1000000000 / SAMPLE_PERIOD_NS;
  // 2*pi*65536 = 411775, coefficient per hertz in Q16
  localparam int unsigned SVF_F_PER_HZ =
    int'((64'd411775 * 64'(SAMPLE_PERIOD_NS)) / 64'd1000000000);

  // Register indices, byte address is index * 4
  localparam int unsigned REG_COUNT  = 17;
  localparam logic [4:0] IDX_FF_GAIN = 5'h00;
  localparam logic [4:0] IDX_FF_TIME = 5'h01;
  localparam logic [4:0] IDX_SW_SEL  = 5'h02;
  localparam logic [4:0] IDX_SW_TRQ  = 5'h03;
  localparam logic [4:0] IDX_SW_SPD  = 5'h04;
  localparam logic [4:0] IDX_SW_ACC  = 5'h05;
  localparam logic [4:0] IDX_SW_PERR = 5'h06;
  localparam logic [4:0] IDX_LAG_TAU = 5'h07;
  localparam logic [4:0] IDX_LPF_F   = 5'h08;
  localparam logic [4:0] IDX_LPF_Q   = 5'h09;
  localparam logic [4:0] IDX_N_SEL   = 5'h0a;
  localparam logic [4:0] IDX_N1_F    = 5'h0b;
  localparam logic [4:0] IDX_N1_Q    = 5'h0c;
  localparam logic [4:0] IDX_N1_D    = 5'h0d;
  localparam logic [4:0] IDX_N2_F    = 5'h0e;
  localparam logic [4:0] IDX_N2_Q    = 5'h0f;
  localparam logic [4:0] IDX_N2_D    = 5'h10;
  localparam logic [4:0] IDX_STATUS  = 5'h11;

  // Reset values
  localparam logic [15:0] RST_FF_GAIN = 16'h0000;
  localparam logic [15:0] RST_FF_TIME = 16'h0000;
  localparam logic [15:0] RST_SW_SEL  = 16'h0000;
  localparam logic [15:0] RST_SW_TRQ  = 16'h00c8;
  localparam logic [15:0] RST_SW_SPD  = 16'h0000;
  localparam logic [15:0] RST_SW_ACC  = 16'h0000;
  localparam logic [15:0] RST_SW_PERR = 16'h0000;
  localparam logic [15:0] RST_LAG_TAU = 16'h0064;
  localparam logic [15:0] RST_LPF_F   = 16'h1388;
  localparam logic [15:0] RST_LPF_Q   = 16'h0032;
  localparam logic [15:0] RST_N_SEL   = 16'h0000;
  localparam logic [15:0] RST_N_F     = 16'h1388;
  localparam logic [15:0] RST_N_Q     = 16'h0046;
  localparam logic [15:0] RST_N_D     = 16'h0000;
  localparam logic [15:0] RST_VALUES [REG_COUNT] = '{
    RST_FF_GAIN, RST_FF_TIME, RST_SW_SEL, RST_SW_TRQ, RST_SW_SPD, RST_SW_ACC,
    RST_SW_PERR, RST_LAG_TAU, RST_LPF_F, RST_LPF_Q, RST_N_SEL,
    RST_N_F, RST_N_Q, RST_N_D, RST_N_F, RST_N_Q, RST_N_D};

  // Field layout and codes
  localparam int unsigned DIGIT0_LSB  = 0;
  localparam int unsigned DIGIT2_LSB  = 8;
  localparam logic [3:0] SW_TORQUE    = 4'h0;
  localparam logic [3:0] SW_SPEED     = 4'h1;
  localparam logic [3:0] SW_ACCEL     = 4'h2;
  localparam logic [3:0] SW_POSERR    = 4'h3;
  localparam logic [3:0] SW_OFF       = 4'h4;
  localparam logic [3:0] NOTCH_ON     = 4'h1;
  localparam logic [15:0] FF_GAIN_MAX = 16'h0064;
  localparam logic [15:0] LPF_BYPASS  = 16'h1388;
  localparam logic [15:0] Q_MIN       = 16'h0032;
  localparam logic [15:0] DEPTH_FULL  = 16'h03e8;
  localparam int unsigned D_SCALE      = 409600;
  localparam int unsigned DEPTH_TO_Q16 = 66;
  localparam int unsigned GAIN_TO_Q16  = 655;

  // Control-side samples, all from logic on the core clock
  typedef struct packed {
    logic               pos_ctrl;
    logic signed [15:0] torque_ref;
    logic signed [15:0] speed_ref;
    logic signed [15:0] pos_ref_delta;
    logic signed [31:0] pos_err;
  } slc_ctrl_t;

  // Q8 value to 16-bit sample with saturation
  function automatic logic signed [15:0] slc_sat16(input logic signed [31:0] v);
    logic signed [23:0] w;
    w = v[31:8];
    if (w > 24'sh007fff) begin
      return 16'sh7fff;
    end
    if (w < -24'sh008000) begin
      return -16'sh8000;
    end
    return w[15:0];
  endfunction

endpackage

// [logic/slc_lag_stage.sv]
// First-order lag stage, one update per sample tick.
// Assumes tick_i is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module slc_lag_stage (
  // Clock, reset, sample strobe
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               tick_i,
  // Time constant in 0.01 ms, sample in
  input  wire logic [15:0]        tau_i,
  input  wire logic signed [15:0] x_i,
  // Filtered sample
  output logic signed [15:0]      y_o
);
  logic [31:0]        den;
  logic [16:0]        alpha;
  logic signed [32:0] diff;
  logic signed [50:0] prod;
  logic signed [31:0] acc_q;
  logic signed [31:0] acc_d;

  // Alpha = T/(tau+T) in Q16; zero tau gives a straight pass
  always_comb begin
    den   = 32'(tau_i) * 32'd10 + 32'(slc_pkg::SAMPLE_US);
    alpha = 17'((32'd65536 * 32'(slc_pkg::SAMPLE_US)) / den);
    diff  = 33'($signed({x_i, 8'h00})) - 33'(acc_q);
    prod  = 51'(diff) * 51'($signed({1'b0, alpha}));
    acc_d = acc_q + 32'(prod >>> 16);
  end

  // Accumulator stays a convex mix of inputs, so it cannot overflow
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_q <= 32'sh0;
    end else if (tick_i) begin
      acc_q <= acc_d;
    end
  end

  assign y_o = acc_q[23:8];
endmodule

// [logic/slc_svf_stage.sv]
// State-variable second-order stage: low-pass or notch, with bypass.
// Assumes settings come from registers on the same clock.
`timescale 1ns/100ps
module slc_svf_stage (
  // Clock, reset, sample strobe
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               tick_i,
  // Mode and settings
  input  wire logic               bypass_i,
  input  wire logic               notch_i,
  input  wire logic [15:0]        freq_i,
  input  wire logic [15:0]        q_i,
  input  wire logic [15:0]        depth_i,
  // Samples
  input  wire logic signed [15:0] x_i,
  output logic signed [15:0]      y_q
);
  logic [16:0]        f;
  logic [13:0]        d;
  logic [16:0]        keep;
  logic [15:0]        qs;
  logic signed [31:0] xs, damp, lp_d, hp, bp_d, yn, ysel;
  logic signed [31:0] lp_q, bp_q;

  // Coefficients follow the settings every sample
  always_comb begin
    f    = 17'(32'(freq_i) * slc_pkg::SVF_F_PER_HZ);
    qs   = (q_i < slc_pkg::Q_MIN) ? slc_pkg::Q_MIN : q_i;
    d    = 14'(slc_pkg::D_SCALE / 32'(qs));
    keep = 17'(32'(slc_pkg::DEPTH_FULL - ((depth_i > slc_pkg::DEPTH_FULL) ?
           slc_pkg::DEPTH_FULL : depth_i)) * slc_pkg::DEPTH_TO_Q16);
    xs   = 32'($signed({x_i, 8'h00}));
    damp = 32'((48'(bp_q) * 48'($signed({1'b0, d}))) >>> 12);
    lp_d = lp_q + 32'((48'(bp_q) * 48'($signed({1'b0, f}))) >>> 16);
    hp   = xs - lp_d - damp;
    bp_d = bp_q + 32'((48'(hp) * 48'($signed({1'b0, f}))) >>> 16);
    yn   = xs - 32'((48'(damp) * 48'($signed({1'b0, keep}))) >>> 16);
    ysel = bypass_i ? xs : (notch_i ? yn : lp_d);
  end

  // States cleared while bypassed so enabling starts the filter from zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lp_q <= 32'sh0;
      bp_q <= 32'sh0;
      y_q  <= 16'sh0;
    end else if (tick_i) begin
      lp_q <= bypass_i ? 32'sh0 : lp_d;
      bp_q <= bypass_i ? 32'sh0 : bp_d;
      y_q  <= slc_pkg::slc_sat16(ysel);
    end
  end

  chk_bypass_passes: assert property (@(posedge clk_i) disable iff (reset_i)
    tick_i && bypass_i |=> y_q == $past(x_i))
    else $error("bypassed stage altered the sample");
endmodule

// [logic/slc_servo_comp.sv]
// Top of the servo loop compensation filters: Wishbone settings, mode switch,
// position feedforward and the torque reference filter chain.
// Assumes control samples arrive on the core clock, read on each sample tick.
`timescale 1ns/100ps

module slc_servo_comp (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Control loop samples
  input  wire slc_pkg::slc_ctrl_t ctrl_i,
  // Control loop results
  output logic signed [15:0]     torque_ref_o,
  output logic signed [15:0]     speed_ff_o,
  output logic                   p_ctrl_o,
  output logic                   sample_tick_o
);
  localparam int unsigned NSTAGE = 3;

  logic [15:0]        cfg_q [slc_pkg::REG_COUNT];
  logic               ack_q;
  logic [31:0]        rdat_q;
  logic [7:0]         div_q;
  logic               tick_q;
  logic               p_ctrl_q;
  logic               pos_ctrl_q;
  logic signed [15:0] torque_q;
  logic signed [15:0] ff_q;
  logic signed [15:0] speed_prev_q;

  logic               req;
  logic               wr_en;
  logic [4:0]         idx;
  logic               idx_cfg;
  logic [15:0]        lane_mask;
  logic [31:0]        status;
  logic [3:0]         sw_sel;
  logic [15:0]        trq_abs, spd_abs;
  logic [16:0]        spd_step;
  logic [33:0]        acc_abs;
  logic [31:0]        perr_abs;
  logic               p_ctrl_d;
  logic [15:0]        gain_eff;
  logic signed [33:0] ff_prod;
  logic signed [15:0] ff_scaled;
  logic signed [15:0] ff_filt;
  logic signed [15:0] lag_out;
  logic signed [15:0] stage_x [NSTAGE];
  logic signed [15:0] stage_y [NSTAGE];
  logic               stage_byp [NSTAGE];
  logic [15:0]        stage_f [NSTAGE];
  logic [15:0]        stage_qv [NSTAGE];
  logic [15:0]        stage_dv [NSTAGE];

  // Bus decode; addresses above the status word read zero
  always_comb begin
    req       = wb_cyc_i && wb_stb_i;
    idx       = wb_adr_i[6:2];
    idx_cfg   = !wb_adr_i[7] && (32'(idx) < slc_pkg::REG_COUNT);
    wr_en     = req && wb_we_i && ack_q && idx_cfg;
    lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    status    = {torque_q, 14'h0000, pos_ctrl_q, p_ctrl_q};
  end

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data captured in the first cycle, held while ack is up
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      if (idx_cfg) begin
        rdat_q <= {16'h0000, cfg_q[idx]};
      end else if (!wb_adr_i[7] && idx == slc_pkg::IDX_STATUS) begin
        rdat_q <= status;
      end else begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  // settings written directly
  // Writes land on the ack edge; upper byte lanes carry nothing
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < slc_pkg::REG_COUNT; i++) begin
        cfg_q[i] <= slc_pkg::RST_VALUES[i];
      end
    end else if (wr_en) begin
      cfg_q[idx] <= (cfg_q[idx] & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
    end
  end

  // Sample tick divider; all filters step on it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q == 8'(slc_pkg::SAMPLE_DIV - 1)) ? 8'h00 : div_q + 8'h01;
      tick_q <= (div_q == 8'(slc_pkg::SAMPLE_DIV - 1));
    end
  end

  // Magnitudes of detected quantities
  always_comb begin
    sw_sel   = cfg_q[slc_pkg::IDX_SW_SEL][slc_pkg::DIGIT0_LSB +: 4];
    trq_abs  = ctrl_i.torque_ref[15] ? 16'(-ctrl_i.torque_ref) : ctrl_i.torque_ref;
    spd_abs  = ctrl_i.speed_ref[15] ? 16'(-ctrl_i.speed_ref) : ctrl_i.speed_ref;
    spd_step = 17'($signed({ctrl_i.speed_ref[15], ctrl_i.speed_ref})
               - $signed({speed_prev_q[15], speed_prev_q}));
    spd_step = spd_step[16] ? 17'(-$signed(spd_step)) : spd_step;
    acc_abs  = 34'(spd_step) * 34'(slc_pkg::SAMPLE_RATE_HZ);
    perr_abs = ctrl_i.pos_err[31] ? 32'(-ctrl_i.pos_err) : ctrl_i.pos_err;
  end

  // condition select
  // A full-scale negative sample still gives its true magnitude, held unsigned
  always_comb begin
    case (sw_sel)
      slc_pkg::SW_TORQUE: p_ctrl_d = trq_abs > cfg_q[slc_pkg::IDX_SW_TRQ];
      slc_pkg::SW_SPEED:  p_ctrl_d = spd_abs > cfg_q[slc_pkg::IDX_SW_SPD];
      slc_pkg::SW_ACCEL:  p_ctrl_d = acc_abs > 34'(cfg_q[slc_pkg::IDX_SW_ACC]);
      slc_pkg::SW_POSERR: p_ctrl_d = ctrl_i.pos_ctrl &&
                                     (perr_abs > 32'(cfg_q[slc_pkg::IDX_SW_PERR]));
      default:            p_ctrl_d = 1'b0;
    endcase
  end

  // Mode and previous speed follow the sample tick
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      p_ctrl_q     <= 1'b0;
      pos_ctrl_q   <= 1'b0;
      speed_prev_q <= 16'sh0;
    end else if (tick_q) begin
      p_ctrl_q     <= p_ctrl_d;
      pos_ctrl_q   <= ctrl_i.pos_ctrl;
      speed_prev_q <= ctrl_i.speed_ref;
    end
  end

  // feedforward gain, clamped at full scale
  always_comb begin
    gain_eff  = (cfg_q[slc_pkg::IDX_FF_GAIN] > slc_pkg::FF_GAIN_MAX) ?
                slc_pkg::FF_GAIN_MAX : cfg_q[slc_pkg::IDX_FF_GAIN];
    ff_prod   = 34'(ctrl_i.pos_ref_delta) *
                34'($signed({1'b0, 17'(32'(gain_eff) * slc_pkg::GAIN_TO_Q16)}));
    ff_scaled = ff_prod[31:16];
  end

  // Feedforward smoothing in 0.01 ms units
  slc_lag_stage u_ff_lag (
    .clk_i   (core_clk_i),
    .reset_i (reset_i),
    .tick_i  (tick_q),
    .tau_i   (cfg_q[slc_pkg::IDX_FF_TIME]),
    .x_i     (ff_scaled),
    .y_o     (ff_filt)
  );

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ff_q <= 16'sh0;
    end else if (tick_q) begin
      ff_q <= ctrl_i.pos_ctrl ? ff_filt : 16'sh0;
    end
  end

  slc_lag_stage u_trq_lag (
    .clk_i   (core_clk_i),
    .reset_i (reset_i),
    .tick_i  (tick_q),
    .tau_i   (cfg_q[slc_pkg::IDX_LAG_TAU]),
    .x_i     (ctrl_i.torque_ref),
    .y_o     (lag_out)
  );

  // Stage settings: low-pass, then the two notches
  always_comb begin
    stage_byp[0] = cfg_q[slc_pkg::IDX_LPF_F] >= slc_pkg::LPF_BYPASS;
    stage_byp[1] = cfg_q[slc_pkg::IDX_N_SEL][slc_pkg::DIGIT0_LSB +: 4] != slc_pkg::NOTCH_ON;
    stage_byp[2] = cfg_q[slc_pkg::IDX_N_SEL][slc_pkg::DIGIT2_LSB +: 4] != slc_pkg::NOTCH_ON;
    stage_f[0]   = cfg_q[slc_pkg::IDX_LPF_F];
    stage_qv[0]  = cfg_q[slc_pkg::IDX_LPF_Q];
    stage_dv[0]  = 16'h0000;
    stage_f[1]   = cfg_q[slc_pkg::IDX_N1_F];
    stage_qv[1]  = cfg_q[slc_pkg::IDX_N1_Q];
    stage_dv[1]  = cfg_q[slc_pkg::IDX_N1_D];
    stage_f[2]   = cfg_q[slc_pkg::IDX_N2_F];
    stage_qv[2]  = cfg_q[slc_pkg::IDX_N2_Q];
    stage_dv[2]  = cfg_q[slc_pkg::IDX_N2_D];
  end

  // stages in series
  // One sample of latency per stage keeps each multiply short
  for (genvar s = 0; s < NSTAGE; s++) begin : g_stage
    if (s == 0) begin : g_head
      assign stage_x[s] = lag_out;
    end else begin : g_link
      assign stage_x[s] = stage_y[s-1];
    end
    // centre, Q and depth per stage
    slc_svf_stage u_svf (
      .clk_i    (core_clk_i),
      .reset_i  (reset_i),
      .tick_i   (tick_q),
      .bypass_i (stage_byp[s]),
      .notch_i  (s != 0),
      .freq_i   (stage_f[s]),
      .q_i      (stage_qv[s]),
      .depth_i  (stage_dv[s]),
      .x_i      (stage_x[s]),
      .y_q      (stage_y[s])
    );
  end

  // Filtered torque registered at the top
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      torque_q <= 16'sh0;
    end else if (tick_q) begin
      torque_q <= stage_y[NSTAGE-1];
    end
  end

  // Outputs, each a flip-flop
  assign wb_dat_o      = rdat_q;
  assign wb_ack_o      = ack_q;
  assign torque_ref_o  = torque_q;
  assign speed_ff_o    = ff_q;
  assign p_ctrl_o      = p_ctrl_q;
  assign sample_tick_o = tick_q;

  // Checks on the core clock domain
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  chk_ack_single: assert property (ack_q |=> !ack_q)
    else $error("ack held for more than one cycle");

  chk_ack_latency: assert property (req && !ack_q |=> ack_q)
    else $error("ack did not follow the strobe");

  chk_write_lands: assert property (wr_en && idx == slc_pkg::IDX_FF_GAIN
    && wb_sel_i[1:0] == 2'b11 |=> cfg_q[slc_pkg::IDX_FF_GAIN] == $past(wb_dat_i[15:0]))
    else $error("gain write not stored");

  chk_tick_spacing: assert property (tick_q |=> !tick_q [*8])
    else $error("sample ticks too close");

  chk_switch_off: assert property (tick_q && sw_sel == slc_pkg::SW_OFF
    |=> !p_ctrl_q)
    else $error("P control with switching disabled");

  chk_torque_switch: assert property (tick_q && sw_sel == slc_pkg::SW_TORQUE
    && trq_abs > cfg_q[slc_pkg::IDX_SW_TRQ] |=> p_ctrl_o ##1 p_ctrl_o)
    else $error("torque above level did not force P control");

  chk_speed_switch: assert property (tick_q && sw_sel == slc_pkg::SW_SPEED
    && spd_abs <= cfg_q[slc_pkg::IDX_SW_SPD] |=> !p_ctrl_o)
    else $error("P control with speed at or below level");

  chk_accel_switch: assert property (tick_q && sw_sel == slc_pkg::SW_ACCEL
    && ctrl_i.speed_ref == speed_prev_q |=> !p_ctrl_o)
    else $error("P control with zero acceleration");

  // position error gated by control type
  chk_poserr_gate: assert property (tick_q && sw_sel == slc_pkg::SW_POSERR
    && !ctrl_i.pos_ctrl |=> !p_ctrl_o)
    else $error("position error switched outside position control");

  chk_poserr_switch: assert property (tick_q && sw_sel == slc_pkg::SW_POSERR
    && ctrl_i.pos_ctrl && perr_abs > 32'(cfg_q[slc_pkg::IDX_SW_PERR]) |=> p_ctrl_o)
    else $error("position error above level did not force P control");

  chk_accel_above: assert property (tick_q && sw_sel == slc_pkg::SW_ACCEL
    && acc_abs > 34'(cfg_q[slc_pkg::IDX_SW_ACC]) |=> p_ctrl_o)
    else $error("acceleration above level did not force P control");

  chk_ff_gated: assert property (tick_q && !ctrl_i.pos_ctrl |=> speed_ff_o == 16'sh0)
    else $error("feedforward outside position control");

  // Main scenarios
  cov_write: cover property (wr_en ##1 !ack_q);
  cov_status_read: cover property (req && !wb_we_i && idx == slc_pkg::IDX_STATUS ##1 ack_q);
  cov_p_rise: cover property (tick_q && !p_ctrl_q ##1 p_ctrl_q);
  cov_notch_on: cover property (tick_q && !stage_byp[1] && !stage_byp[2]);
  cov_accel_p: cover property (tick_q && sw_sel == slc_pkg::SW_ACCEL ##1 p_ctrl_q);
endmodule

// [verif/tb.sv]
// Self-checking bench for the servo loop compensation filters.
// Assumes slc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
module tb;
  logic               core_clk_i = 1'b0;
  logic               reset_i    = 1'b1;
  logic               wb_cyc_i   = 1'b0;
  logic               wb_stb_i   = 1'b0;
  logic               wb_we_i    = 1'b0;
  logic [7:0]         wb_adr_i   = 8'h00;
  logic [3:0]         wb_sel_i   = 4'h0;
  logic [31:0]        wb_dat_i   = 32'h0;
  slc_pkg::slc_ctrl_t ctrl_i     = '0;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic signed [15:0] torque_ref_o;
  logic signed [15:0] speed_ff_o;
  logic               p_ctrl_o;
  logic               sample_tick_o;
  int                 fails    = 0;
  int                 n_checks = 0;
  int                 seed     = 32'h10cb77ba;
  logic [15:0]        mdl [17];
  logic [31:0]        rd;

  // Clock at 10 MHz
  always #50 core_clk_i = ~core_clk_i;

  slc_servo_comp dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctrl_i(ctrl_i),
    .torque_ref_o(torque_ref_o), .speed_ff_o(speed_ff_o), .p_ctrl_o(p_ctrl_o),
    .sample_tick_o(sample_tick_o));

  // Verdict and end of run
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle; request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) fails++;
  endtask

  // Wait for k sample ticks, then let outputs settle
  task automatic ticks(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 2400) begin
      @(posedge core_clk_i);
      n++;
      if (sample_tick_o === 1'b1) k--;
    end
    if (k > 0) fails++;  // Tick never came
    @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  // Feedforward term with gain clamped to full scale
  function automatic logic [15:0] ff_exp(input logic signed [15:0] dl, input int g);
    longint p;
    p = longint'(dl) * ((g > 100) ? 100 : g) * 655;
    return 16'(p >>> 16);
  endfunction

  // Proportional-only request for a select code; strict comparisons
  function automatic logic p_exp(input int sl, input longint lv, input slc_pkg::slc_ctrl_t c,
                                 input logic signed [15:0] pv);
    longint q;
    case (sl)
      0: q = c.torque_ref;
      1: q = c.speed_ref;
      2: q = (longint'(c.speed_ref) - pv) * 40000;
      3: q = c.pos_ctrl ? longint'(c.pos_err) : 0;
      default: return 1'b0;
    endcase
    return ((q < 0) ? -q : q) > lv;
  endfunction

  initial begin
    int                 i;
    int                 g;
    int                 k;
    int                 lv;
    logic [31:0]        d;
    logic [3:0]         s;
    logic signed [15:0] t;
    logic signed [15:0] pv;
    slc_pkg::slc_ctrl_t c;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // Defaults of every setting
    for (i = 0; i < 17; i++) begin
      wb(1'b0, 8'(i * 4), 4'hf, 32'h0);
      chk("reset value", {16'h0, slc_pkg::RST_VALUES[i]}, rd);
      mdl[i] = slc_pkg::RST_VALUES[i];
    end
    // Unmapped place ignores writes and reads zero
    wb(1'b1, 8'h80, 4'hf, 32'h1234);
    wb(1'b0, 8'h80, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Random byte-enabled writes read back at once
    repeat (24) begin
      i = $unsigned($random(seed)) % 17;
      d = $random(seed);
      s = 4'($random(seed));
      wb(1'b1, 8'(i * 4), s, d);
      if (s[0]) mdl[i][7:0] = d[7:0];
      if (s[1]) mdl[i][15:8] = d[15:8];
      wb(1'b0, 8'(i * 4), 4'hf, 32'h0);
      chk("readback", {16'h0, mdl[i]}, rd);
    end
    // Sample period between two ticks
    ticks(1);
    k = 1;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (sample_tick_o !== 1'b1 && k < 400);
    chk("tick period", 32'(slc_pkg::SAMPLE_DIV), 32'(k));
    // Torque chain: lag smooths a step, then bypassed stages pass exactly
    wb(1'b1, 8'h20, 4'hf, 32'd5000);
    wb(1'b1, 8'h28, 4'hf, 32'h0);
    wb(1'b1, 8'h1c, 4'hf, 32'd100);
    @(posedge core_clk_i);
    ctrl_i.torque_ref <= 16'sd8000;
    ticks(7);
    chk("lag step", 32'h1, 32'(torque_ref_o > 0 && torque_ref_o < 16'sd8000));
    wb(1'b1, 8'h1c, 4'hf, 32'h0);
    ticks(7);
    chk("lag pass", 32'd8000, 32'(torque_ref_o));
    t = 16'($random(seed));
    @(posedge core_clk_i);
    ctrl_i.torque_ref <= t;
    ticks(7);
    chk("chain pass", 32'(t), 32'(torque_ref_o));
    // Notches set with torque at rest; zero depth cuts a step, full depth passes it
    @(posedge core_clk_i);
    ctrl_i.torque_ref <= 16'sh0;
    ticks(7);
    wb(1'b1, 8'h2c, 4'hf, 32'd400);
    wb(1'b1, 8'h38, 4'hf, 32'd800);
    wb(1'b1, 8'h30, 4'hf, 32'd70);
    wb(1'b1, 8'h34, 4'hf, 32'h0);
    wb(1'b1, 8'h40, 4'hf, 32'd1000);
    wb(1'b1, 8'h08, 4'hf, 32'd4);
    wb(1'b1, 8'h28, 4'hf, 32'h0101);
    @(posedge core_clk_i);
    ctrl_i.torque_ref <= 16'sd8000;
    ticks(7);
    chk("notch cut", 32'h1, 32'(torque_ref_o > 0 && torque_ref_o < 16'sd8000));
    wb(1'b1, 8'h34, 4'hf, 32'd1000);
    ticks(7);
    chk("notch open", 32'd8000, 32'(torque_ref_o));
    wb(1'b0, 8'h44, 4'hf, 32'h0);
    chk("status", 32'h1f40_0000, rd);
    // Feedforward at zero, full, over-range and random gain
    wb(1'b1, 8'h04, 4'hf, 32'h0);
    for (i = 0; i < 4; i++) begin
      g = (i == 0) ? 0 : (i == 1) ? 100 : (i == 2) ? 200 : $unsigned($random(seed)) % 81;
      t = 16'($random(seed));
      wb(1'b1, 8'h00, 4'hf, 32'(g));
      @(posedge core_clk_i);
      ctrl_i.pos_ctrl      <= 1'b1;
      ctrl_i.pos_ref_delta <= t;
      ticks(3);
      chk("feedforward", {16'h0, ff_exp(t, g)}, {16'h0, speed_ff_o});
      @(posedge core_clk_i);
      ctrl_i.pos_ctrl <= 1'b0;
      ticks(2);
      chk("feedforward off", 32'h0, 32'(speed_ff_o));
    end
    // Mode switch over all codes, quantities around the level
    @(posedge core_clk_i);
    ctrl_i <= '0;
    ticks(1);
    pv = 16'sh0;
    repeat (40) begin
      i  = $unsigned($random(seed)) % 5;
      lv = $unsigned($random(seed)) % 801;
      wb(1'b1, 8'h08, 4'hf, 32'(i));
      if (i < 4) wb(1'b1, 8'(12 + 4 * i), 4'hf, 32'(lv));
      t = 16'(lv + ($unsigned($random(seed)) % 3) - 1);
      if ($random(seed) & 1) t = -t;
      c = '{pos_ctrl: 1'($random(seed)), torque_ref: t, speed_ref: (($random(seed) & 1) ? pv : t),
            pos_ref_delta: 16'sh0, pos_err: 32'(t)};
      @(posedge core_clk_i);
      ctrl_i <= c;
      ticks(1);
      chk("p control", 32'(p_exp(i, lv, c, pv)), 32'(p_ctrl_o));
      pv = c.speed_ref;
    end
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge core_clk_i);
    fails++;
    end_sim();
  end
endmodule
